// ### hdl/tlb_pkg.sv
// Shared types and constants for the I/O address translation unit
// ==========================================================================
// What this block does
// R1: Translate 32-bit bus address to 40-bit system
// R2: Every translation yields a snoop virtual index
// R3: Output page type: fast, prefetch, hold enable
// R4: Directory reads use untranslated address directly
// R5: Three modes; real mode after reset
// R6: Software stages entry, then issues command
// R7: IO-space addresses bypass table, ones-extended
// R8: Non single-word IO-space access logs error
// R9: Real mode: extend, index from bits 19:12
// R10: Real mode: safe type, hold on, no prefetch
// R11: Table holds 256 entries; error mode uses only these
// R12: Error mode miss: no fetch, hard error
// R13: Error mode loads only by direct load
// R14: Normal miss: fetch entry, write, retry lookup
// R15: Invalid fetched entry: second miss is hard error
// R16: Normal mode: direct load or fetch preloads
// R17: Chain mask sets addressable space 32/28/24
// R18: Translation maps memory in 4K pages
// R19: Memory accesses are coherent in every mode
// R20: Directory address is base plus page number
// R21: Purge only a valid, fully matching entry
// R22: Direct load reports ready after table write
// R23: Translation hard error blocks DMA until reset or error clear
package tlb_pkg;

    // ======================================================================
    // Widths and sizes
    localparam int ADDR_W     = 32;   // Bus address
    localparam int SYS_W      = 40;   // System address
    localparam int PAGE_W     = 20;   // Page number
    localparam int OFF_W      = 12;   // 4K page offset
    localparam int IDX_W      = 8;    // Table index
    localparam int TBL_DEPTH  = 256;  // Table entries
    localparam int PPN_W      = 28;   // Physical page number
    localparam int VIDX_W     = 8;    // Snoop virtual index
    localparam int PDIR_SHIFT = 3;    // Directory entry is 8 bytes

    // ======================================================================
    // Address fields and extension values
    localparam logic [3:0] IO_NIBBLE = 4'hF;   // IO space marker
    localparam logic [7:0] EXT_ONES  = 8'hFF;  // IO space extension
    localparam logic [7:0] EXT_ZERO  = 8'h00;  // Memory extension
    localparam int         VIDX_LSB  = 12;     // Real mode index bits
    localparam logic [OFF_W-1:0] OFF_ZERO = 12'h000;

    // ======================================================================
    // Chain field masks
    localparam logic [31:0] MASK_32 = 32'hFF00_0000;
    localparam logic [31:0] MASK_28 = 32'h0FF0_0000;
    localparam logic [31:0] MASK_24 = 32'h00FF_0000;

    // ======================================================================
    // Modes, commands, states
    typedef enum logic [1:0] {
        MODE_REAL   = 2'b00,
        MODE_ERROR  = 2'b01,
        MODE_NORMAL = 2'b10
    } xlate_mode_e;

    typedef enum logic [1:0] {
        CMD_PURGE  = 2'b00,
        CMD_INSERT = 2'b01,
        CMD_DIRECT = 2'b10,
        CMD_NOP    = 2'b11
    } tlb_cmd_e;

    typedef enum logic [2:0] {
        S_IDLE       = 3'b000,
        S_CMD        = 3'b001,
        S_LOOKUP     = 3'b010,
        S_FETCH_REQ  = 3'b011,
        S_FETCH_WAIT = 3'b100
    } tlb_state_e;

    // ======================================================================
    // Carriers
    typedef struct packed {
        logic              valid;     // Entry usable
        logic              fast;      // Quick transfer mapping
        logic              prefetch;  // Prefetch allowed
        logic              hold_en;   // Lock line may hold others
        logic [VIDX_W-1:0] vindex;    // Snoop index
        logic [23:0]       rsvd;      // Unused
        logic [PPN_W-1:0]  ppn;       // Physical page
    } pdir_entry_s;

    typedef struct packed {
        logic              valid;
        logic [PAGE_W-1:0] tag;       // Full page number
        logic [PPN_W-1:0]  ppn;
        logic [VIDX_W-1:0] vindex;
        logic              fast;
        logic              prefetch;
        logic              hold_en;
    } tlb_line_s;

    typedef struct packed {
        logic [SYS_W-1:0]  sys_addr;  // Translated address
        logic [VIDX_W-1:0] vindex;
        logic              fast;
        logic              prefetch;
        logic              hold_en;
        logic              coherent;  // Coherent transaction
        logic              io_space;  // IO space bypass
    } xlate_resp_s;

    typedef struct packed {
        logic              pend;
        tlb_cmd_e          op;
        logic [PAGE_W-1:0] page;
    } cmd_s;

    typedef struct packed {
        tlb_state_e        state;
        xlate_mode_e       mode;
        logic [ADDR_W-1:0] work_addr;
        logic              work_sww;
        logic              retried;
        logic              is_insert;
        cmd_s              cmd;
        logic              req_ready;
        logic              resp_valid;
        xlate_resp_s       resp;
        logic              rd_valid;
        logic [SYS_W-1:0]  rd_addr;
        logic              status_ready;
        logic              hard_error;
        logic              err_improper;
        logic              err_fault;
    } tlb_regs_s;

    // ======================================================================
    // Reset values
    localparam tlb_regs_s REGS_RESET = '{
        state:        S_IDLE,
        mode:         MODE_REAL,  // R5
        cmd:          '{pend: 1'b0, op: CMD_NOP, page: '0},
        req_ready:    1'b1,
        status_ready: 1'b1,
        default:      '0
    };

endpackage

// ### hdl/chain_index_select.sv
// Chain field extraction: table index and addressable range check
`timescale 1ns/10ps
module chain_index_select
    import tlb_pkg::*;
(
    input  wire logic [PAGE_W-1:0] page,
    input  wire logic [31:0]       mask,
    output logic      [IDX_W-1:0]  idx,
    output logic                   in_range
);

    // ======================================================================
    // Mask decode
    // Index comes from the masked field; page bits above it must be zero
    always_comb begin
        if (mask == MASK_28) begin                          // R17
            idx      = page[15:8];
            in_range = (page[19:16] == 4'h0);
        end else if (mask == MASK_24) begin                 // R17
            idx      = page[11:4];
            in_range = (page[19:12] == 8'h00);
        end else begin
            // Full 32-bit space, also any unlisted mask
            idx      = page[19:12];
            in_range = 1'b1;
        end
    end

endmodule

// ### hdl/io_address_translation_tlb.sv
// I/O address translation: table, lookup, directory fetch, errors
`timescale 1ns/10ps
module io_address_translation_tlb
    import tlb_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              mode_wr,
    input  wire xlate_mode_e       mode_wdata,
    input  wire logic [31:0]       chain_field_mask,
    input  wire logic [SYS_W-1:0]  directory_base_pointer,
    input  wire pdir_entry_s       staging_entry,
    input  wire logic              cmd_valid,
    input  wire tlb_cmd_e          cmd_op,
    input  wire logic [PAGE_W-1:0] cmd_page,
    input  wire logic              err_clear,
    input  wire logic              req_valid,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic              req_single_word_write,
    output logic                   req_ready,
    output logic                   resp_valid,
    output xlate_resp_s            resp,
    output logic                   mem_rd_valid,
    output logic      [SYS_W-1:0]  mem_rd_addr,
    input  wire logic              mem_rd_accept,
    input  wire logic              mem_rd_data_valid,
    input  wire pdir_entry_s       mem_rd_data,
    output xlate_mode_e            translation_mode_reg,
    output logic                   status_ready,
    output logic                   hard_error,
    output logic                   err_improper,
    output logic                   err_fault
);

    // ======================================================================
    // Storage and working signals
    tlb_line_s         tlb_mem [TBL_DEPTH];  // Translation table
    tlb_regs_s         regs;                 // All control state
    tlb_regs_s         next_regs;            // Its next value
    logic [PAGE_W-1:0] work_page;            // Page being handled
    logic [IDX_W-1:0]  idx;                  // Table slot
    logic              in_range;             // Page inside space
    tlb_line_s         line;                 // Slot contents
    logic              tag_hit;              // Valid and tag match
    logic              hit;                  // Usable translation
    logic              io_addr;              // IO space address
    logic [SYS_W-1:0]  pdir_addr;            // Directory entry address
    logic              tbl_we;               // Table write strobe
    tlb_line_s         tbl_wdata;            // Table write data

    assign work_page = regs.work_addr[ADDR_W-1:OFF_W];

    // Slot select from the chain field
    chain_index_select chain_index_select_i (
        .page     (work_page),
        .mask     (chain_field_mask),
        .idx      (idx),
        .in_range (in_range)
    );

    // ======================================================================
    // Lookup terms
    assign line    = tlb_mem[idx];
    assign tag_hit = line.valid && (line.tag == work_page);       // R21
    assign hit     = tag_hit && in_range;
    assign io_addr = (regs.work_addr[ADDR_W-1:ADDR_W-4] == IO_NIBBLE);
    // Plain address into memory, no translation applied
    assign pdir_addr = directory_base_pointer                   // R4
        + {{(SYS_W-PAGE_W-PDIR_SHIFT){1'b0}}, work_page,        // R20
           {PDIR_SHIFT{1'b0}}};

    // ======================================================================
    // Table write port
    // No reset: software clears every slot before use
    always_ff @(posedge clock) begin
        if (tbl_we) begin
            tlb_mem[idx] <= tbl_wdata;                          // R11
        end
    end

    // ======================================================================
    // Next state of the controller
    always_comb begin
        next_regs            = regs;
        next_regs.resp_valid = 1'b0;
        tbl_we               = 1'b0;
        tbl_wdata            = line;
        // Mode select; the unused code is ignored
        if (mode_wr && (mode_wdata != 2'b11)) begin
            next_regs.mode = mode_wdata;                        // R5
        end
        // Command capture while idle for commands
        if (cmd_valid && regs.status_ready) begin
            next_regs.cmd          = '{pend: 1'b1, op: cmd_op,
                                       page: cmd_page};
            next_regs.status_ready = 1'b0;
        end
        // Clear first so a same-cycle error still sets
        if (err_clear) begin
            next_regs.hard_error   = 1'b0;                      // R23
            next_regs.err_improper = 1'b0;
            next_regs.err_fault    = 1'b0;
        end
        case (regs.state)
            S_IDLE: begin
                if (req_valid && regs.req_ready) begin
                    // Accept one inbound transaction
                    next_regs.work_addr = req_addr;
                    next_regs.work_sww  = req_single_word_write;
                    next_regs.retried   = 1'b0;
                    next_regs.state     = S_LOOKUP;
                end else if (regs.cmd.pend) begin
                    // Start a pending command
                    next_regs.work_addr = {regs.cmd.page, OFF_ZERO};
                    next_regs.cmd.pend  = 1'b0;
                    next_regs.state     = S_CMD;
                end
            end
            S_CMD: begin
                next_regs.state        = S_IDLE;
                next_regs.status_ready = 1'b1;                  // R22
                case (regs.cmd.op)
                    CMD_DIRECT: begin
                        // Staged entry is stable until ready
                        tbl_we    = 1'b1;                       // R6
                        tbl_wdata = '{valid:    staging_entry.valid,
                                      tag:      work_page,
                                      ppn:      staging_entry.ppn,
                                      vindex:   staging_entry.vindex,
                                      fast:     staging_entry.fast,
                                      prefetch: staging_entry.prefetch,
                                      hold_en:  staging_entry.hold_en};
                    end
                    CMD_PURGE: begin
                        // Only a full page match is removed
                        tbl_we          = tag_hit;              // R21
                        tbl_wdata.valid = 1'b0;
                    end
                    CMD_INSERT: begin
                        // Fetch only with a directory present
                        if (regs.mode == MODE_NORMAL) begin     // R13 R16
                            next_regs.is_insert    = 1'b1;
                            next_regs.rd_valid     = 1'b1;
                            next_regs.rd_addr      = pdir_addr;
                            next_regs.state        = S_FETCH_REQ;
                            next_regs.status_ready = 1'b0;
                        end
                    end
                    default: begin
                        // No operation
                        next_regs.state = S_IDLE;
                    end
                endcase
            end
            S_LOOKUP: begin
                next_regs.state         = S_IDLE;
                next_regs.resp.coherent = !io_addr;             // R19
                next_regs.resp.io_space = io_addr;
                if (io_addr) begin
                    // Bypass the table in every mode
                    if (!regs.work_sww) begin
                        next_regs.hard_error   = 1'b1;          // R8
                        next_regs.err_improper = 1'b1;
                    end else begin
                        next_regs.resp_valid    = 1'b1;
                        next_regs.resp.sys_addr = {EXT_ONES,    // R7
                                                   regs.work_addr};
                        next_regs.resp.vindex   = '0;
                        next_regs.resp.fast     = 1'b0;
                        next_regs.resp.prefetch = 1'b0;
                        next_regs.resp.hold_en  = 1'b0;
                    end
                end else if (regs.mode == MODE_REAL) begin
                    // Equivalent mapping with fixed safe type
                    next_regs.resp_valid    = 1'b1;
                    next_regs.resp.sys_addr = {EXT_ZERO,        // R9
                                               regs.work_addr};
                    next_regs.resp.vindex   =                   // R9 R2
                        regs.work_addr[VIDX_LSB+VIDX_W-1:VIDX_LSB];
                    next_regs.resp.fast     = 1'b0;             // R10
                    next_regs.resp.prefetch = 1'b0;             // R10
                    next_regs.resp.hold_en  = 1'b1;             // R10
                end else if (hit) begin
                    // Table translation, 4K page granules
                    next_regs.resp_valid    = 1'b1;
                    next_regs.resp.sys_addr = {line.ppn,        // R1 R18
                                        regs.work_addr[OFF_W-1:0]};
                    next_regs.resp.vindex   = line.vindex;      // R2
                    next_regs.resp.fast     = line.fast;        // R3
                    next_regs.resp.prefetch = line.prefetch;    // R3
                    next_regs.resp.hold_en  = line.hold_en;     // R3
                end else if (regs.mode == MODE_NORMAL
                             && !regs.retried) begin
                    // First miss goes to the directory
                    next_regs.rd_valid = 1'b1;                  // R14
                    next_regs.rd_addr  = pdir_addr;             // R20
                    next_regs.state    = S_FETCH_REQ;
                end else begin
                    // Error mode miss or repeated miss
                    next_regs.hard_error = 1'b1;                // R12 R15
                    next_regs.err_fault  = 1'b1;
                end
            end
            S_FETCH_REQ: begin
                // Hold the read until the bus takes it
                if (mem_rd_accept) begin
                    next_regs.rd_valid = 1'b0;
                    next_regs.state    = S_FETCH_WAIT;
                end
            end
            S_FETCH_WAIT: begin
                if (mem_rd_data_valid) begin
                    tbl_we    = 1'b1;                           // R14
                    tbl_wdata = '{valid:    mem_rd_data.valid,
                                  tag:      work_page,
                                  ppn:      mem_rd_data.ppn,
                                  vindex:   mem_rd_data.vindex,
                                  fast:     mem_rd_data.fast,
                                  prefetch: mem_rd_data.prefetch,
                                  hold_en:  mem_rd_data.hold_en};
                    if (regs.is_insert) begin
                        next_regs.is_insert    = 1'b0;
                        next_regs.status_ready = 1'b1;
                        next_regs.state        = S_IDLE;
                    end else begin
                        // Retry with the fresh entry
                        next_regs.retried = 1'b1;               // R14
                        next_regs.state   = S_LOOKUP;
                    end
                end
            end
            default: begin
                next_regs.state = S_IDLE;
            end
        endcase
        // Take requests only idle, error free, no command queued
        next_regs.req_ready = (next_regs.state == S_IDLE)       // R23
            && !next_regs.hard_error && !next_regs.cmd.pend;
    end

    // ======================================================================
    // State registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            regs <= REGS_RESET;
        end else begin
            regs <= next_regs;
        end
    end

    // ======================================================================
    // Outputs, all from registers
    assign req_ready            = regs.req_ready;
    assign resp_valid           = regs.resp_valid;
    assign resp                 = regs.resp;
    assign mem_rd_valid         = regs.rd_valid;
    assign mem_rd_addr          = regs.rd_addr;
    assign translation_mode_reg = regs.mode;
    assign status_ready         = regs.status_ready;
    assign hard_error           = regs.hard_error;
    assign err_improper         = regs.err_improper;
    assign err_fault            = regs.err_fault;

    // ======================================================================
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    logic lk_mem;  // Lookup of a memory address
    assign lk_mem = (regs.state == S_LOOKUP) && !io_addr;

    AST_IO_EXTEND: assert property ( // R7
        resp_valid && resp.io_space |-> resp.sys_addr[39:28] == 12'hFFF)
        else $error("IO space address not ones extended");
    AST_REAL_INDEX: assert property ( // R9
        lk_mem && regs.mode == MODE_REAL && !mode_wr |=> resp_valid
        && resp.vindex == resp.sys_addr[19:12]
        && resp.sys_addr[39:32] == 8'h00)
        else $error("Real mode index or extension wrong");
    AST_REAL_TYPE: assert property ( // R10
        lk_mem && regs.mode == MODE_REAL |=> !resp.fast
        && !resp.prefetch && resp.hold_en)
        else $error("Real mode page type wrong");
    AST_COHERENT: assert property ( // R19
        resp_valid |-> resp.coherent == !resp.io_space)
        else $error("Coherent flag wrong");
    AST_IMPROPER: assert property ( // R8
        regs.state == S_LOOKUP && io_addr && !regs.work_sww
        |=> hard_error && err_improper && !resp_valid)
        else $error("Improper IO access not logged");
    AST_ERR_MISS: assert property ( // R12
        lk_mem && regs.mode == MODE_ERROR && !hit
        |=> hard_error && err_fault && !mem_rd_valid ##1 !mem_rd_valid)
        else $error("Error mode miss handled wrongly");
    AST_MISS_FETCH: assert property ( // R14
        lk_mem && regs.mode == MODE_NORMAL && !hit && !regs.retried
        |=> mem_rd_valid && mem_rd_addr == $past(pdir_addr))
        else $error("Normal miss did not fetch");
    AST_RETRY: assert property ( // R14
        regs.state == S_FETCH_WAIT && mem_rd_data_valid
        && !regs.is_insert |=> regs.state == S_LOOKUP && regs.retried)
        else $error("Fetched entry not retried");
    AST_SECOND_MISS: assert property ( // R15
        lk_mem && regs.mode == MODE_NORMAL && regs.retried && !hit
        |=> hard_error && err_fault)
        else $error("Second miss not logged");
    AST_DIRECT_READY: assert property ( // R22
        cmd_valid && status_ready && cmd_op == CMD_DIRECT
        && regs.state == S_IDLE && !regs.cmd.pend
        && !(req_valid && req_ready)
        |=> !status_ready [*2] ##1 status_ready)
        else $error("Direct load ready timing wrong");
    AST_BLOCK: assert property ( // R23
        hard_error |-> !req_ready)
        else $error("Requests taken during hard error");

    COV_HIT: cover property (lk_mem && hit && regs.mode != MODE_REAL);
    COV_FETCH: cover property (regs.state == S_FETCH_WAIT
        && mem_rd_data_valid && !regs.is_insert);
    COV_IMPROPER: cover property (err_improper);
    COV_PURGE: cover property (regs.state == S_CMD
        && regs.cmd.op == CMD_PURGE && tag_hit);

endmodule

// ### tb/dir_mem.sv
// Memory model answering page directory reads
`timescale 1ns/10ps
module dir_mem
    import tlb_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             mem_rd_valid,
    input  wire logic [SYS_W-1:0] mem_rd_addr,
    output logic                  mem_rd_accept,
    output logic                  mem_rd_data_valid,
    output pdir_entry_s           mem_rd_data
);
    logic [SYS_W-1:0] last = '0; // Last address taken
    initial {mem_rd_accept, mem_rd_data_valid, mem_rd_data} = '0;
    // Late accept, one data beat, scrambled data when idle
    always @(posedge clock) begin
        mem_rd_data_valid <= mem_rd_accept & mem_rd_valid;
        mem_rd_accept <= mem_rd_valid & ~mem_rd_accept;
        if (mem_rd_accept & mem_rd_valid) begin
            last <= mem_rd_addr;
            mem_rd_data <= {~mem_rd_addr[22], 3'b011,
                mem_rd_addr[10:3], 24'h0, mem_rd_addr[30:3]};
        end else
            mem_rd_data <= ~mem_rd_data;
    end
endmodule

// ### tb/io_address_translation_tlb_tb.sv
// Self-checking bench for the translation unit
`timescale 1ns/10ps
module io_address_translation_tlb_tb
    import tlb_pkg::*;
;
    localparam logic [SYS_W-1:0] BASE = 40'h00_1000_0000;
    logic clock = 0, sys_rst = 1, mode_wr = 0, cmd_valid = 0;
    logic err_clear = 0, req_valid = 0, req_single_word_write = 0;
    logic req_ready, resp_valid, mem_rd_valid, mem_rd_accept;
    logic mem_rd_data_valid, status_ready, hard_error, err_improper;
    logic err_fault;
    xlate_mode_e mode_wdata = MODE_REAL, translation_mode_reg;
    tlb_cmd_e cmd_op = CMD_NOP;
    logic [PAGE_W-1:0] cmd_page = '0;
    logic [ADDR_W-1:0] req_addr = '0;
    logic [31:0] mask = MASK_32; // Chain field mask under test
    logic [SYS_W-1:0] mem_rd_addr, m;
    pdir_entry_s staging_entry = '0, mem_rd_data;
    xlate_resp_s resp, r;
    int n_fail = 0, checks_done = 0, cyc = 0;
    io_address_translation_tlb io_address_translation_tlb_i (
        .clock, .sys_rst, .mode_wr, .mode_wdata, .cmd_valid, .cmd_op,
        .chain_field_mask(mask), .directory_base_pointer(BASE),
        .staging_entry, .cmd_page, .err_clear, .req_valid, .req_addr,
        .req_single_word_write, .req_ready, .resp_valid, .resp,
        .mem_rd_valid, .mem_rd_addr, .mem_rd_accept, .mem_rd_data_valid,
        .mem_rd_data, .translation_mode_reg, .status_ready, .hard_error,
        .err_improper, .err_fault);
    dir_mem dir_mem_i (.clock, .mem_rd_valid, .mem_rd_addr,
        .mem_rd_accept, .mem_rd_data_valid, .mem_rd_data);
    always #2.5 clock = ~clock;
    // Hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            close_out;
        end
    end
    task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
        checks_done++;
        if (e !== g) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cmd(tlb_cmd_e op, logic [19:0] pg);
        cmd_op = op;
        cmd_page = pg;
        cmd_valid = 1;
        @(negedge clock) cmd_valid = 0;
        @(negedge clock) while (!status_ready) @(negedge clock);
    endtask
    task automatic xl(logic [31:0] a, logic w);
        while (req_ready !== 1) @(negedge clock);
        {req_addr, req_single_word_write, req_valid} = {a, w, 1'b1};
        @(negedge clock) req_valid = 0;
        repeat (30) if (!resp_valid && !hard_error) @(negedge clock);
        r = resp;
    endtask
    task automatic setmode(xlate_mode_e md);
        mode_wdata = md;
        mode_wr = 1;
        @(negedge clock) mode_wr = 0;
    endtask
    task automatic clr;
        err_clear = 1;
        @(negedge clock) err_clear = 0;
        @(negedge clock) chk("clr", 0, hard_error);
    endtask
    task automatic close_out;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clock);
        sys_rst = 0;
        @(negedge clock) chk("mode", MODE_REAL, translation_mode_reg);
        xl(32'h1234_5678, 0);
        chk("real", {8'h00, 32'h1234_5678, 8'h45, 5'b00110}, r);
        xl(32'hF000_0ABC, 1);
        chk("io", {8'hFF, 32'hF000_0ABC}, r.sys_addr);
        xl(32'hF000_0010, 0);
        chk("imp", 2'b11, {hard_error, err_improper});
        clr;
        setmode(MODE_ERROR);
        for (int i = 0; i < 256; i++) cmd(CMD_DIRECT, 20'(i << 12));
        staging_entry = {4'b1110, 8'hA5, 24'h0, 28'h0ABCDEF};
        cmd(CMD_DIRECT, 20'h12000);
        cmd(CMD_PURGE, 20'h12001);
        xl(32'h1200_0123, 0);
        chk("hit", {28'h0ABCDEF, 12'h123, 8'hA5, 5'b11010}, r);
        cmd(CMD_PURGE, 20'h12000);
        xl(32'h1200_0123, 0);
        chk("emiss", 3'b100, {hard_error, mem_rd_valid, |dir_mem_i.last});
        clr;
        setmode(MODE_NORMAL);
        xl(32'h5601_2777, 0);
        m = BASE + {20'h56012, 3'b0};
        chk("fadr", m, dir_mem_i.last);
        chk("norm", {m[30:3], 12'h777, m[10:3], 5'b01110}, r);
        xl(32'h8000_0000, 0);
        chk("fault", 3'b110, {hard_error, err_fault, req_ready});
        clr;
        cmd(CMD_INSERT, 20'h3A0B0);
        chk("ins", BASE + {20'h3A0B0, 3'b0}, dir_mem_i.last);
        // 28-bit space: slots from page bits 15:8, upper nibble zero
        mask = MASK_28;
        cmd(CMD_DIRECT, 20'h0AB00);
        staging_entry = '0;
        cmd(CMD_DIRECT, 20'h0AC00);
        xl(32'h0AB0_0456, 0);
        chk("m28", {28'h0ABCDEF, 12'h456}, r.sys_addr);
        xl(32'h1AB0_0000, 0);
        chk("range", 2'b11, {hard_error, err_fault});
        close_out;
    end
endmodule
